/* File: hdl/channel_bank.sv */
// one channel's private write and read register bank
`timescale 1ns/1ps
module channel_bank
  import serial_regs_pkg::*;
#(
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          chan_reset,
  // register write port
  input  wire logic          wr_en,
  input  wire logic [3:0]    wr_idx,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic          rd_buffer,
  // receive side
  input  wire logic          rx_strobe,
  input  wire logic [DW-1:0] rx_data,
  // external status inputs, already synchronised
  input  wire logic          cts,
  input  wire logic          dcd,
  input  wire logic          sync_in,
  // read view
  input  wire logic [3:0]    rd_idx,
  output logic      [DW-1:0] rd_data,
  // decoded controls
  output logic               rts_out,
  output logic               dtr_out,
  output logic      [DW-1:0] tx_data,
  output logic               tx_valid,
  output logic               crc_cmd_pulse
);
  logic [DW-1:0] wreg [0:15];
  logic [DW-1:0] rxbuf_reg;
  logic          rx_avail_reg;
  logic          overrun_reg;
  logic          tx_full_reg;
  logic          crc_pulse_reg;
  logic [DW-1:0] status0;
  logic [DW-1:0] status1;
  logic [DW-1:0] status10;
  wire           err_reset = wr_en && (wr_idx == IDX_COMMAND) &&
                 (wr_data[CMD_FIELD_LSB +: CMD_FIELD_W] == CMD_RESET_ERR);
  wire           is_wreg  = wr_en && (wr_idx != IDX_VECTOR) && (wr_idx != IDX_MASTER_INT);

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_wreg
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          wreg[g] <= (g == 15) ? RST_EXT_IRQ : RST_ZERO;
        end else if (ce) begin
          if (chan_reset) begin
            wreg[g] <= (g == 15) ? RST_EXT_IRQ : RST_ZERO;
          end else if (is_wreg && (wr_idx == 4'(g)) && (g != 0)) begin
            wreg[g] <= wr_data;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxbuf_reg     <= RST_ZERO;
      rx_avail_reg  <= 1'b0;
      overrun_reg   <= 1'b0;
      tx_full_reg   <= 1'b0;
      crc_pulse_reg <= 1'b0;
    end else if (ce) begin
      crc_pulse_reg <= wr_en && (wr_idx == IDX_COMMAND) &&
                       (wr_data[CRC_CMD_LSB +: 2] != CRC_CMD_NONE);
      if (chan_reset) begin
        rx_avail_reg <= 1'b0;
        overrun_reg  <= 1'b0;
        tx_full_reg  <= 1'b0;
      end else begin
        if (rx_strobe) begin
          rxbuf_reg    <= rx_data;
          rx_avail_reg <= 1'b1;
        end else if (rd_buffer) begin
          rx_avail_reg <= 1'b0;
        end
        if (rx_strobe && rx_avail_reg && !rd_buffer) begin
          overrun_reg <= 1'b1;
        end else if (err_reset) begin
          overrun_reg <= 1'b0;
        end
        tx_full_reg <= (wr_en && wr_idx == IDX_BUFFER) ? 1'b1 : 1'b0;
      end
    end
  end

  // status words
  always_comb begin
    status0 = RST_ZERO;
    status0[ST_RX_AVAIL] = rx_avail_reg;
    status0[ST_TX_EMPTY] = !tx_full_reg;
    status0[ST_DCD]      = dcd;
    status0[ST_SYNC]     = sync_in;
    status0[ST_CTS]      = cts;
  end
  always_comb begin
    status1 = RST_ZERO;
    status1[SR_ALL_SENT] = !tx_full_reg;
    status1[SR_OVERRUN]  = overrun_reg;
  end
  always_comb begin
    status10 = RST_MISC_ST;
    status10[ECHO_BIT]     = wreg[IDX_GEN_LOOP][ECHO_BIT];
    status10[LOOPBACK_BIT] = wreg[IDX_GEN_LOOP][LOOPBACK_BIT];
  end

  // read selection
  always_comb begin
    case (rd_idx)
      4'h0:        rd_data = status0;
      4'h1:        rd_data = status1;
      IDX_BUFFER:  rd_data = rxbuf_reg;
      IDX_LINE_CODING: rd_data = status10;
      IDX_TC_LOW:  rd_data = wreg[IDX_TC_LOW];
      IDX_TC_HIGH: rd_data = wreg[IDX_TC_HIGH];
      IDX_EXT_IRQ: rd_data = wreg[IDX_EXT_IRQ];
      default:     rd_data = RST_ZERO;
    endcase
  end

  assign rts_out       = wreg[IDX_TX_CTRL][RTS_BIT];
  assign dtr_out       = wreg[IDX_TX_CTRL][DTR_BIT];
  assign tx_data       = wreg[IDX_BUFFER];
  assign tx_valid      = tx_full_reg;
  assign crc_cmd_pulse = crc_pulse_reg;
endmodule

/* File: hdl/serial_controller_regs.sv */
// two-channel register set behind a classic wishbone slave
// Operation
// - each channel has fourteen write and seven read registers of its own.
// - vector and master interrupt registers exist once, shared by both channels.
// - per channel four status, two time constant, one buffer read; two shared reads.
// - vector read on channel B is status modified, on A unmodified; here B is modified only while master bit VIS_BIT is set.
// - pending bits readable through channel A only, covering both channels.
// - time constant written as low and high bytes, read back likewise.
// - command register triggers actions including crc initialisation resets.
// - interrupt enable register also configures the wait/request output.
// - receive control sets bits per character and receive crc enable.
// - shared parameters: clock multiplier, sync count, stop bits, parity.
// - transmit control sets bits per character and transmit crc enable.
// - sync first byte register, transmit buffer, and receive buffer.
// - master register holds reset commands and daisy chain controls.
// - line coding register selects nrz, nrzi or fm and crc preset.
// - clock source register selects receive and transmit clock sources.
// - generator and loop register controls baud generator, pll, echo, loopback.
// - external status interrupt control written and read back per channel.
// - status read gives buffer states and external status inputs.
// - special receive status gives residue and error conditions; here only overrun and all sent, no residue.
// - misc status read gives transmitter and receiver status; here only the echo and loopback bits of the generator and loop register.
// - modem inputs monitored and outputs driven, usable as general purpose.
// - read and write strobes together act as a reset.
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module serial_controller_regs
  import serial_regs_pkg::*;
#(
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          CLK,
  input  wire logic          RST_N,
  input  wire logic          CE,
  // wishbone slave
  input  wire logic          WB_CYC_I,
  input  wire logic          WB_STB_I,
  input  wire logic          WB_WE_I,
  input  wire logic [7:0]    WB_ADR_I,
  input  wire logic [3:0]    WB_SEL_I,
  input  wire logic [31:0]   WB_DAT_I,
  output logic      [31:0]   WB_DAT_O,
  output logic               WB_ACK_O,
  // strobe coincidence reset request
  input  wire logic          STROBE_RESET,
  // receive data from the receiver datapath
  input  wire logic          RX_STROBE_A,
  input  wire logic [DW-1:0] RX_DATA_A,
  input  wire logic          RX_STROBE_B,
  input  wire logic [DW-1:0] RX_DATA_B,
  // modem inputs, active low pins
  input  wire logic          CTS_N_A,
  input  wire logic          DCD_N_A,
  input  wire logic          SYNC_N_A,
  input  wire logic          CTS_N_B,
  input  wire logic          DCD_N_B,
  input  wire logic          SYNC_N_B,
  // interrupt pending inputs from interrupt logic
  input  wire logic [5:0]    PENDING_IN,
  input  wire logic [2:0]    VECTOR_STATUS,
  // modem outputs, active low pins
  output logic               RTS_N_A,
  output logic               DTR_N_A,
  output logic               RTS_N_B,
  output logic               DTR_N_B,
  // transmit buffer to transmitter datapath
  output logic      [DW-1:0] TX_DATA_A,
  output logic               TX_VALID_A,
  output logic      [DW-1:0] TX_DATA_B,
  output logic               TX_VALID_B,
  // crc command pulses and master controls
  output logic               CRC_CMD_A,
  output logic               CRC_CMD_B,
  output logic      [DW-1:0] MASTER_CTRL
);
  logic          rst_meta_reg;
  logic          rst_sync_reg;
  logic [5:0]    in_meta_reg;
  logic [5:0]    in_sync_reg;
  logic          ack_reg;
  logic [31:0]   dat_reg;
  logic [DW-1:0] vector_reg;
  logic [DW-1:0] master_reg;
  logic          srst_meta_reg;
  logic          srst_sync_reg;
  logic          reset_a;
  logic          reset_b;
  logic [DW-1:0] rd_a;
  logic [DW-1:0] rd_b;
  logic          rts_a;
  logic          dtr_a;
  logic          rts_b;
  logic          dtr_b;

  // reset release synchroniser
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  // pin synchronisers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_reg   <= 6'h00;
      in_sync_reg   <= 6'h00;
      srst_meta_reg <= 1'b0;
      srst_sync_reg <= 1'b0;
    end else if (CE) begin
      in_meta_reg   <= {!SYNC_N_B, !DCD_N_B, !CTS_N_B, !SYNC_N_A, !DCD_N_A, !CTS_N_A};
      in_sync_reg   <= in_meta_reg;
      srst_meta_reg <= STROBE_RESET;
      srst_sync_reg <= srst_meta_reg;
    end
  end

  // bus decode
  wire       req       = WB_CYC_I && WB_STB_I && !ack_reg;
  wire       commit    = WB_CYC_I && WB_STB_I && ack_reg && CE;
  wire       chan_b    = WB_ADR_I[ADR_CHAN_BIT];
  wire [3:0] idx       = WB_ADR_I[ADR_IDX_LSB +: 4];
  wire       lane0     = WB_SEL_I[0];
  wire       wr_strobe = commit && WB_WE_I && lane0;
  wire       rd_strobe = req && !WB_WE_I && CE;
  wire       mapped    = (WB_ADR_I[7] == 1'b0) && (WB_ADR_I[1:0] == 2'b00);
  wire       wr_ok     = wr_strobe && mapped;
  wire [DW-1:0] wdat   = WB_DAT_I[DW-1:0];
  wire       wr_a      = wr_ok && !chan_b;
  wire       wr_b      = wr_ok && chan_b;
  wire       wr_vector = wr_ok && (idx == IDX_VECTOR);
  wire       wr_master = wr_ok && (idx == IDX_MASTER_INT);
  wire       rd_buf_a  = rd_strobe && mapped && !chan_b && (idx == IDX_BUFFER);
  wire       rd_buf_b  = rd_strobe && mapped && chan_b && (idx == IDX_BUFFER);
  wire [1:0] mrst      = wdat[MASTER_RST_LSB +: 2];
  wire       hard_rst  = srst_sync_reg || (wr_master && mrst == MRST_HARD);

  assign reset_a = hard_rst || (wr_master && mrst == MRST_CH_A);
  assign reset_b = hard_rst || (wr_master && mrst == MRST_CH_B);

  // shared registers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      vector_reg <= RST_ZERO;
      master_reg <= RST_MASTER;
    end else if (CE) begin
      if (hard_rst) begin
        master_reg <= RST_MASTER;
      end else if (wr_master) begin
        master_reg <= {MRST_NONE, wdat[5:0]};
      end
      if (wr_vector) begin
        vector_reg <= wdat;
      end
    end
  end

  // shared read views
  wire [DW-1:0] vec_mod  = master_reg[VIS_BIT] ?
                           {vector_reg[7:4], VECTOR_STATUS, vector_reg[0]} : vector_reg;
  wire [DW-1:0] vec_rd   = chan_b ? vec_mod : vector_reg;
  wire [DW-1:0] pend_rd  = chan_b ? RST_ZERO : {2'b00, PENDING_IN};
  wire [DW-1:0] bank_rd  = chan_b ? rd_b : rd_a;
  wire [DW-1:0] sel_rd   = (idx == IDX_VECTOR)  ? vec_rd :
                           (idx == IDX_PENDING) ? pend_rd : bank_rd;
  wire [31:0]   rd_word  = mapped ? {24'h000000, sel_rd} : 32'h00000000;

  // wishbone answer, one cycle after the request
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else if (CE) begin
      ack_reg <= req;
      if (req && !WB_WE_I) begin
        dat_reg <= rd_word;
      end
    end
  end
  assign WB_ACK_O = commit;
  assign WB_DAT_O = dat_reg;

  // channel banks: all registers except vector, master interrupt and command
  // are banked write registers of the instances
  channel_bank #(.DW(DW)) u_bank_a (
    .clk           (CLK),
    .rst_n         (rst_n),
    .ce            (CE),
    .chan_reset    (reset_a),
    .wr_en         (wr_a),
    .wr_idx        (idx),
    .wr_data       (wdat),
    .rd_buffer     (rd_buf_a),
    .rx_strobe     (RX_STROBE_A),
    .rx_data       (RX_DATA_A),
    .cts           (in_sync_reg[0]),
    .dcd           (in_sync_reg[1]),
    .sync_in       (in_sync_reg[2]),
    .rd_idx        (idx),
    .rd_data       (rd_a),
    .rts_out       (rts_a),
    .dtr_out       (dtr_a),
    .tx_data       (TX_DATA_A),
    .tx_valid      (TX_VALID_A),
    .crc_cmd_pulse (CRC_CMD_A)
  );
  channel_bank #(.DW(DW)) u_bank_b (
    .clk           (CLK),
    .rst_n         (rst_n),
    .ce            (CE),
    .chan_reset    (reset_b),
    .wr_en         (wr_b),
    .wr_idx        (idx),
    .wr_data       (wdat),
    .rd_buffer     (rd_buf_b),
    .rx_strobe     (RX_STROBE_B),
    .rx_data       (RX_DATA_B),
    .cts           (in_sync_reg[3]),
    .dcd           (in_sync_reg[4]),
    .sync_in       (in_sync_reg[5]),
    .rd_idx        (idx),
    .rd_data       (rd_b),
    .rts_out       (rts_b),
    .dtr_out       (dtr_b),
    .tx_data       (TX_DATA_B),
    .tx_valid      (TX_VALID_B),
    .crc_cmd_pulse (CRC_CMD_B)
  );

  // modem outputs, pins are active low
  assign RTS_N_A     = !rts_a;
  assign DTR_N_A     = !dtr_a;
  assign RTS_N_B     = !rts_b;
  assign DTR_N_B     = !dtr_b;
  assign MASTER_CTRL = master_reg;
endmodule

/* File: hdl/serial_regs_pkg.sv */
// register offsets, field positions and reset values of the two-channel register set
package serial_regs_pkg;
  // register indices within a channel's bank (byte address = 4 * index)
  localparam logic [3:0] IDX_COMMAND     = 4'h0;
  localparam logic [3:0] IDX_INT_DMA     = 4'h1;
  localparam logic [3:0] IDX_VECTOR      = 4'h2;
  localparam logic [3:0] IDX_PENDING     = 4'h3;
  localparam logic [3:0] IDX_RX_CTRL     = 4'h3;
  localparam logic [3:0] IDX_MISC_PARAMS = 4'h4;
  localparam logic [3:0] IDX_TX_CTRL     = 4'h5;
  localparam logic [3:0] IDX_SYNC_FIRST  = 4'h6;
  localparam logic [3:0] IDX_SYNC_SECOND = 4'h7;
  localparam logic [3:0] IDX_BUFFER      = 4'h8;
  localparam logic [3:0] IDX_MASTER_INT  = 4'h9;
  localparam logic [3:0] IDX_LINE_CODING = 4'ha;
  localparam logic [3:0] IDX_CLOCK_SRC   = 4'hb;
  localparam logic [3:0] IDX_TC_LOW      = 4'hc;
  localparam logic [3:0] IDX_TC_HIGH     = 4'hd;
  localparam logic [3:0] IDX_GEN_LOOP    = 4'he;
  localparam logic [3:0] IDX_EXT_IRQ     = 4'hf;
  // address layout: bits [5:2] index, bit 6 channel (1 = channel B)
  localparam int ADR_IDX_LSB = 2;
  localparam int ADR_CHAN_BIT = 6;
  // field positions
  localparam int CMD_FIELD_LSB   = 3;
  localparam int CMD_FIELD_W     = 3;
  localparam int CRC_CMD_LSB     = 6;
  localparam int MASTER_RST_LSB  = 6;
  localparam int VIS_BIT         = 0;
  localparam int RTS_BIT         = 1;
  localparam int DTR_BIT         = 7;
  localparam int GEN_ENABLE_BIT  = 0;
  localparam int ECHO_BIT        = 3;
  localparam int LOOPBACK_BIT    = 4;
  localparam int RX_ENABLE_BIT   = 0;
  localparam int TX_ENABLE_BIT   = 3;
  // status bit positions in the buffer/external status word
  localparam int ST_RX_AVAIL  = 0;
  localparam int ST_TX_EMPTY  = 2;
  localparam int ST_DCD       = 3;
  localparam int ST_SYNC      = 4;
  localparam int ST_CTS       = 5;
  // status bit positions in the special receive word
  localparam int SR_OVERRUN   = 5;
  localparam int SR_ALL_SENT  = 0;
  // reset values
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_EXT_IRQ  = 8'hf8;
  localparam logic [7:0] RST_MASTER   = 8'hc0;
  localparam logic [7:0] RST_MISC_ST  = 8'h00;
  // command codes in the command field
  localparam logic [2:0] CMD_NULL        = 3'h0;
  localparam logic [2:0] CMD_RESET_ERR   = 3'h6;
  localparam logic [1:0] CRC_CMD_NONE    = 2'h0;
  // master reset field codes
  localparam logic [1:0] MRST_NONE  = 2'h0;
  localparam logic [1:0] MRST_CH_B  = 2'h1;
  localparam logic [1:0] MRST_CH_A  = 2'h2;
  localparam logic [1:0] MRST_HARD  = 2'h3;
endpackage

/* File: verif/host_bus_model.sv */
// host cpu model speaking classic wishbone
`timescale 1ns/1ps
module host_bus_model (
  // clock
  input  wire logic        clk,
  // wishbone master
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic      [7:0]  adr,
  output logic      [3:0]  sel,
  output logic      [31:0] dat_w,
  input  wire logic        ack,
  input  wire logic [31:0] dat_r
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0;
  end
  // one cycle; address carries channel and register index
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat_w <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~a;
    dat_w <= ~{24'h0, d};
  endtask
endmodule

/* File: verif/regs_assertions.sv */
// bus and control checks for the register set
`timescale 1ns/1ps
module regs_assertions #(
  parameter int DW = 8
) (
  // clock and reset
  input wire logic          CLK,
  input wire logic          RST_N,
  input wire logic          CE,
  // wishbone
  input wire logic          WB_CYC_I,
  input wire logic          WB_STB_I,
  input wire logic          WB_WE_I,
  input wire logic [7:0]    WB_ADR_I,
  input wire logic [3:0]    WB_SEL_I,
  input wire logic [31:0]   WB_DAT_I,
  input wire logic [31:0]   WB_DAT_O,
  input wire logic          WB_ACK_O,
  // controls
  input wire logic          RTS_N_A,
  input wire logic          DTR_N_A,
  input wire logic          TX_VALID_A,
  input wire logic          CRC_CMD_A,
  input wire logic          TX_VALID_B,
  input wire logic          CRC_CMD_B,
  input wire logic [DW-1:0] MASTER_CTRL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] wdat_reg;
  // data input byte of the last acknowledged transfer, read or write
  always_ff @(posedge CLK) begin
    if (WB_ACK_O) begin
      wdat_reg <= WB_DAT_I[7:0];
    end
  end
  sequence req_s;
    WB_CYC_I && WB_STB_I && CE && !WB_ACK_O;
  endsequence
  sequence wr_s(logic [7:0] a);
    WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0] && WB_ADR_I == a;
  endsequence
  sequence rd_s;
    WB_CYC_I && WB_STB_I && !WB_WE_I && WB_ACK_O;
  endsequence
  ack_follows_a: assert property (req_s |=> WB_ACK_O)
    else $error("no ack after request");
  ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  rts_follow_a: assert property (wr_s(8'h14) |-> ##[1:2] RTS_N_A == !wdat_reg[1])
    else $error("rts pin wrong");
  dtr_follow_a: assert property (wr_s(8'h14) |-> ##[1:2] DTR_N_A == !wdat_reg[7])
    else $error("dtr pin wrong");
  tx_pulse_a: assert property (wr_s(8'h20) |-> ##[0:2] TX_VALID_A)
    else $error("no transmit valid");
  crc_pulse_a: assert property (wr_s(8'h00) ##0 WB_DAT_I[7:6] != 2'h0 |-> ##[0:2] CRC_CMD_A)
    else $error("no crc pulse");
  tx_pulse_b_a: assert property (wr_s(8'h60) |-> ##[0:2] TX_VALID_B)
    else $error("no transmit valid on channel b");
  crc_pulse_b_a: assert property (wr_s(8'h40) ##0 WB_DAT_I[7:6] != 2'h0
    |-> ##[0:2] CRC_CMD_B)
    else $error("no crc pulse on channel b");
  crc_quiet_a: assert property (wr_s(8'h00) ##0 WB_DAT_I[7:6] == 2'h0 |=> !CRC_CMD_A [*2])
    else $error("spurious crc pulse");
  master_wr_a: assert property ((wr_s(8'h24) or wr_s(8'h64)) ##0 WB_DAT_I[7:6] == 2'h0
    |-> ##[1:2] MASTER_CTRL == {2'h0, wdat_reg[5:0]})
    else $error("master register wrong");
  read_upper_a: assert property (rd_s |-> WB_DAT_O[31:8] == 24'h0)
    else $error("read upper bits set");
  pend_b_a: assert property (rd_s ##0 WB_ADR_I == 8'h4c |-> WB_DAT_O == 32'h0)
    else $error("pending bits via channel b");
  unmapped_a: assert property (rd_s ##0 WB_ADR_I[7] |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
endmodule

/* File: verif/serial_controller_regs_test.sv */
// self-checking bench for the two-channel register set
`timescale 1ns/1ps
module serial_controller_regs_test
  import serial_regs_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        strobe_reset = 1'b0;
  logic        rx_stb_a = 1'b0;
  logic [7:0]  rx_dat_a = 8'h00;
  logic        rx_stb_b = 1'b0;
  logic [7:0]  rx_dat_b = 8'h00;
  logic        cts_n_a = 1'b1;
  logic        dcd_n_a = 1'b1;
  logic        sync_n_a = 1'b1;
  logic        sync_n_b = 1'b1;
  logic [5:0]  pend = 6'h00;
  logic [2:0]  vstat = 3'h0;
  logic        cyc, stb, we, ack, rts_n_a, dtr_n_a, rts_n_b, dtr_n_b;
  logic [7:0]  adr, mctl, txd_a, txd_b, q;
  logic [3:0]  sel;
  logic [31:0] dw, dr;
  int          bad_count = 0;
  int          n_compared = 0;
  always #10 clk = ~clk;
  host_bus_model host_u (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_w(dw), .ack(ack), .dat_r(dr));
  serial_controller_regs dut_u (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw),
    .WB_DAT_O(dr), .WB_ACK_O(ack), .STROBE_RESET(strobe_reset), .RX_STROBE_A(rx_stb_a),
    .RX_DATA_A(rx_dat_a), .RX_STROBE_B(rx_stb_b), .RX_DATA_B(rx_dat_b), .CTS_N_A(cts_n_a),
    .DCD_N_A(dcd_n_a), .SYNC_N_A(sync_n_a), .CTS_N_B(1'b1), .DCD_N_B(1'b1),
    .SYNC_N_B(sync_n_b), .PENDING_IN(pend), .VECTOR_STATUS(vstat), .RTS_N_A(rts_n_a),
    .DTR_N_A(dtr_n_a), .RTS_N_B(rts_n_b), .DTR_N_B(dtr_n_b), .TX_DATA_A(txd_a), .TX_VALID_A(),
    .TX_DATA_B(txd_b), .TX_VALID_B(), .CRC_CMD_A(), .CRC_CMD_B(), .MASTER_CTRL(mctl));
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input int ch, input logic [3:0] i, input logic [7:0] d);
    host_u.xfer(1'b1, {1'b0, ch[0], i, 2'b00}, d, q);
  endtask
  task automatic rchk(input int ch, input logic [3:0] i, input logic [7:0] e,
                      input logic [7:0] m = 8'hff);
    host_u.xfer(1'b0, {1'b0, ch[0], i, 2'b00}, 8'h00, q);
    chk(q & m, e);
  endtask
  task automatic rx_byte(input int ch, input logic [7:0] d);
    if (ch[0]) begin
      rx_dat_b <= d;
      rx_stb_b <= 1'b1;
    end else begin
      rx_dat_a <= d;
      rx_stb_a <= 1'b1;
    end
    idle(1);
    rx_stb_a <= 1'b0;
    rx_stb_b <= 1'b0;
    idle(2);
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic t_banks;
    rchk(0, IDX_EXT_IRQ, RST_EXT_IRQ);
    chk(mctl, RST_MASTER);
    wr(0, IDX_TC_LOW, 8'h34);
    wr(0, IDX_TC_HIGH, 8'h12);
    wr(1, IDX_TC_LOW, 8'hcd);
    wr(0, IDX_EXT_IRQ, 8'h5a);
    rchk(0, IDX_TC_LOW, 8'h34);
    rchk(0, IDX_TC_HIGH, 8'h12);
    rchk(1, IDX_TC_LOW, 8'hcd);
    rchk(1, IDX_TC_HIGH, RST_ZERO);
    rchk(0, IDX_EXT_IRQ, 8'h5a);
    rchk(1, IDX_EXT_IRQ, RST_EXT_IRQ);
  endtask
  task automatic t_shared;
    wr(0, IDX_VECTOR, 8'h30);
    wr(1, IDX_MASTER_INT, 8'h01);
    vstat <= 3'h5;
    pend <= 6'h2a;
    idle(2);
    chk(mctl, 8'h01);
    rchk(0, IDX_VECTOR, 8'h30);
    rchk(1, IDX_VECTOR, 8'h3a);
    rchk(0, IDX_PENDING, 8'h2a);
    rchk(1, IDX_PENDING, 8'h00);
  endtask
  task automatic t_modem;
    wr(0, IDX_TX_CTRL, 8'h82);
    cts_n_a <= 1'b0;
    dcd_n_a <= 1'b0;
    sync_n_b <= 1'b0;
    idle(4);
    chk({6'h0, rts_n_a, dtr_n_a}, 8'h00);
    chk({6'h0, rts_n_b, dtr_n_b}, 8'h03);
    rchk(0, IDX_COMMAND, 8'h28, 8'h38);
    rchk(1, IDX_COMMAND, 8'h10, 8'h38);
  endtask
  task automatic t_data;
    rx_byte(0, 8'h6c);
    rchk(0, IDX_COMMAND, 8'h01, 8'h01);
    rchk(0, IDX_BUFFER, 8'h6c);
    rchk(0, IDX_COMMAND, 8'h00, 8'h01);
    rx_byte(1, 8'h77);
    rchk(0, IDX_COMMAND, 8'h00, 8'h01);
    rchk(1, IDX_COMMAND, 8'h01, 8'h01);
    rchk(1, IDX_BUFFER, 8'h77);
    rx_byte(0, 8'h11);
    rx_byte(0, 8'h22);
    rchk(0, IDX_INT_DMA, 8'h20, 8'h20);
    wr(0, IDX_COMMAND, 8'h30);
    rchk(0, IDX_INT_DMA, 8'h00, 8'h20);
    wr(0, IDX_COMMAND, 8'h40);
    wr(1, IDX_COMMAND, 8'h80);
    wr(0, IDX_GEN_LOOP, 8'h18);
    rchk(0, IDX_LINE_CODING, 8'h18, 8'h18);
    wr(0, IDX_BUFFER, 8'h5c);
    wr(1, IDX_BUFFER, 8'ha5);
    idle(2);
    chk(txd_b, 8'ha5);
    chk(txd_a, 8'h5c);
    host_u.xfer(1'b1, 8'hb0, 8'hee, q);
    rchk(0, IDX_TC_LOW, 8'h34);
    host_u.xfer(1'b0, 8'h81, 8'h00, q);
    chk(q, 8'h00);
  endtask
  task automatic t_strobe;
    strobe_reset <= 1'b1;
    idle(4);
    strobe_reset <= 1'b0;
    idle(4);
    chk(mctl, RST_MASTER);
    rchk(0, IDX_TC_LOW, RST_ZERO);
    rchk(0, IDX_EXT_IRQ, RST_EXT_IRQ);
  endtask
  initial begin
    idle(5);
    rst_n <= 1'b1;
    idle(3);
    t_banks;
    t_shared;
    t_modem;
    t_data;
    t_strobe;
    stop_test;
  end
  initial begin
    idle(20000);
    bad_count++;
    stop_test;
  end
endmodule
bind serial_controller_regs regs_assertions #(.DW(DW)) chk_u (.CLK(CLK), .RST_N(RST_N),
  .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .RTS_N_A(RTS_N_A), .DTR_N_A(DTR_N_A), .TX_VALID_A(TX_VALID_A),
  .CRC_CMD_A(CRC_CMD_A), .TX_VALID_B(TX_VALID_B), .CRC_CMD_B(CRC_CMD_B),
  .MASTER_CTRL(MASTER_CTRL));
